// ===== hdl/cfs_pkg.sv
// Package for the fetch and execute sequencer
package cfs_pkg;

  localparam int PC_W = 13;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int OFFS_W = 7;
  localparam int BANK_W = 2;
  localparam int DADDR_W = BANK_W + OFFS_W;

  // Implemented program space: 10, 11, 12 or 13 address bits
  localparam int PROG_ADDR_BITS = 13;
  localparam logic [PC_W-1:0] PROG_MASK =
    PC_W'((32'h1 << PROG_ADDR_BITS) - 32'h1);

  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;

  // Special function register layout inside every bank
  localparam logic [OFFS_W-1:0] STATUS_OFFS = 7'h03;
  localparam logic [OFFS_W-1:0] PCLATH_OFFS = 7'h0a;
  localparam logic [OFFS_W-1:0] SFR_TOP = 7'h20;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h18;
  localparam logic [DATA_W-1:0] PCLATH_RESET = 8'h00;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam int BANK_HI_BIT = 6;
  localparam int BANK_LO_BIT = 5;
  localparam int ZERO_BIT = 2;
  localparam int PCLATH_JUMP_HI = 4;
  localparam int PCLATH_JUMP_LO = 3;

  localparam logic [INSN_W-1:0] NOP_WORD = 14'h0000;

  // Phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_ONE = 2'b00,
    PH_TWO = 2'b01,
    PH_THREE = 2'b10,
    PH_FOUR = 2'b11
  } cfs_phase_type;

  // Operation classes
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_MOVWF = 3'b001,
    OP_MOVF = 3'b010,
    OP_ADDWF = 3'b011,
    OP_BCF = 3'b100,
    OP_BSF = 3'b101,
    OP_MOVLW = 3'b110,
    OP_JUMP = 3'b111
  } cfs_op_type;

  // Opcode fields
  localparam logic [6:0] ENC_MOVWF = 7'b0000001;
  localparam logic [5:0] ENC_MOVF = 6'b001000;
  localparam logic [5:0] ENC_ADDWF = 6'b000111;
  localparam logic [3:0] ENC_BCF = 4'b0100;
  localparam logic [3:0] ENC_BSF = 4'b0101;
  localparam logic [3:0] ENC_MOVLW = 4'b1100;
  localparam logic [1:0] ENC_JUMP = 2'b10;

  typedef struct packed {
    cfs_op_type op;
    logic rd_f;
    logic wr_f;
    logic wr_w;
    logic jump;
  } cfs_dec_type;

  // Data memory request towards the banked memory
  typedef struct packed {
    logic [DADDR_W-1:0] addr;
    logic rd;
    logic wr;
    logic [DATA_W-1:0] wdata;
    logic sfr;
  } cfs_dmem_req_type;

  localparam cfs_dmem_req_type DMEM_IDLE = '0;

endpackage : cfs_pkg

// ===== hdl/cfs_core_fetch_execute_sequencer.sv
// Fetch and execute sequencer of the 8-bit core
// Function
// - Divide oscillator by four into phases
// - Advance program counter in phase one
// - Capture program word in phase four
// - Overlap next fetch with current execution
// - Present instruction phase one, execute two-four
// - Operand read phase two, write phase four
// - Jumps take two cycles, prefetch discarded
// - Thirteen-bit counter, 8K by 14 space
// - Addresses wrap onto implemented program memory
// - Start at zero, interrupt vector four
// - Two status bits select data bank
// - Each bank holds 128 byte locations
// - Low bank locations are special registers
// - Frequent special registers mirrored across banks
`timescale 1ns/1ps
`default_nettype none

module cfs_core_fetch_execute_sequencer
  import cfs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [cfs_pkg::INSN_W-1:0] prog_word_i,
  input wire logic [cfs_pkg::DATA_W-1:0] dmem_rdata_i,
  input wire logic irq_i,
  output logic [cfs_pkg::PC_W-1:0] prog_addr_o,
  output logic [3:0] phase_o,
  output cfs_pkg::cfs_dmem_req_type dmem_o,
  output logic irq_ack_o,
  output logic [cfs_pkg::DATA_W-1:0] w_o,
  output logic [cfs_pkg::DATA_W-1:0] status_o
);
  import cfs_pkg::*;

  cfs_phase_type phase_q;
  logic [PC_W-1:0] pc_q;
  logic [INSN_W-1:0] ir_q;
  logic [INSN_W-1:0] exec_q;
  logic exec_valid_q;
  logic kill_q;
  logic [DATA_W-1:0] operand_q;
  logic [DATA_W-1:0] result_q;
  logic [DATA_W-1:0] pclath_q;
  cfs_dec_type dec_next;
  cfs_dec_type dec;
  logic [BANK_W-1:0] bank;
  logic next_internal;
  logic exec_internal;
  logic take_irq;
  logic redirect;
  logic [PC_W-1:0] target;
  logic [DATA_W-1:0] bit_mask;
  logic [DATA_W-1:0] sfr_value;

  function automatic cfs_dec_type decode(input logic [INSN_W-1:0] insn);
    cfs_dec_type d;
    d = '0;
    d.op = OP_NONE;
    if (insn[13:7] == ENC_MOVWF)
    begin
      d.op = OP_MOVWF;
      d.wr_f = 1'b1;
    end
    else if (insn[13:8] == ENC_MOVF || insn[13:8] == ENC_ADDWF)
    begin
      d.op = (insn[13:8] == ENC_MOVF) ? OP_MOVF : OP_ADDWF;
      d.rd_f = 1'b1;
      d.wr_f = insn[7];
      d.wr_w = ~insn[7];
    end
    else if (insn[13:10] == ENC_BCF || insn[13:10] == ENC_BSF)
    begin
      d.op = (insn[13:10] == ENC_BCF) ? OP_BCF : OP_BSF;
      d.rd_f = 1'b1;
      d.wr_f = 1'b1;
    end
    else if (insn[13:10] == ENC_MOVLW)
    begin
      d.op = OP_MOVLW;
      d.wr_w = 1'b1;
    end
    else if (insn[13:12] == ENC_JUMP)
    begin
      d.op = OP_JUMP;
      d.jump = 1'b1;
    end
    return d;
  endfunction : decode

  // Bank and mirrored register decode
  assign bank = {status_o[BANK_HI_BIT], status_o[BANK_LO_BIT]};
  assign dec_next = decode(ir_q);
  assign dec = decode(exec_q);
  assign next_internal = (ir_q[6:0] == STATUS_OFFS) ||
                         (ir_q[6:0] == PCLATH_OFFS);
  assign exec_internal = (exec_q[6:0] == STATUS_OFFS) ||
                         (exec_q[6:0] == PCLATH_OFFS);
  assign sfr_value = (exec_q[6:0] == STATUS_OFFS) ? status_o : pclath_q;
  assign bit_mask = DATA_W'(8'h01 << exec_q[9:7]);

  // Branch and interrupt redirection at the end of phase four
  assign take_irq = irq_i && exec_valid_q && !dec.jump;
  assign redirect = (exec_valid_q && dec.jump) || take_irq;
  assign target = take_irq ? INT_VECTOR :
                  {pclath_q[PCLATH_JUMP_HI:PCLATH_JUMP_LO], exec_q[10:0]};

  // Phase generator
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      phase_q <= PH_ONE;
      phase_o <= 4'h1;
    end
    else
    begin
      case (phase_q)
        PH_ONE:
        begin
          phase_q <= PH_TWO;
          phase_o <= 4'h2;
        end
        PH_TWO:
        begin
          phase_q <= PH_THREE;
          phase_o <= 4'h4;
        end
        PH_THREE:
        begin
          phase_q <= PH_FOUR;
          phase_o <= 4'h8;
        end
        default:
        begin
          phase_q <= PH_ONE;
          phase_o <= 4'h1;
        end
      endcase
    end
  end

  // Program counter and fetch
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pc_q <= RESET_VECTOR;
      prog_addr_o <= RESET_VECTOR;
      ir_q <= NOP_WORD;
    end
    else
    begin
      case (phase_q)
        PH_ONE:
        begin
          prog_addr_o <= pc_q & PROG_MASK;
          pc_q <= PC_W'(pc_q + 13'h0001) & PROG_MASK;
        end
        PH_FOUR:
        begin
          ir_q <= prog_word_i;
          if (redirect)
          begin
            pc_q <= target & PROG_MASK;
          end
        end
        default:
        begin
          pc_q <= pc_q;
        end
      endcase
    end
  end

  // Execution stage and flush
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      exec_q <= NOP_WORD;
      exec_valid_q <= 1'b0;
      kill_q <= 1'b0;
      irq_ack_o <= 1'b0;
    end
    else
    begin
      irq_ack_o <= 1'b0;
      case (phase_q)
        PH_ONE:
        begin
          exec_q <= ir_q;
          exec_valid_q <= ~kill_q;
          kill_q <= 1'b0;
        end
        PH_FOUR:
        begin
          kill_q <= redirect;
          irq_ack_o <= take_irq;
        end
        default:
        begin
          kill_q <= kill_q;
        end
      endcase
    end
  end

  // Data memory operand read and destination write
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      dmem_o <= DMEM_IDLE;
      operand_q <= '0;
      result_q <= '0;
    end
    else
    begin
      case (phase_q)
        PH_ONE:
        begin
          dmem_o.addr <= {bank, ir_q[6:0]};
          dmem_o.sfr <= (ir_q[6:0] < SFR_TOP);
          dmem_o.rd <= ~kill_q && dec_next.rd_f && !next_internal;
          dmem_o.wr <= 1'b0;
        end
        PH_TWO:
        begin
          operand_q <= exec_internal ? sfr_value : dmem_rdata_i;
          dmem_o.rd <= 1'b0;
        end
        PH_THREE:
        begin
          case (dec.op)
            OP_MOVWF: result_q <= w_o;
            OP_MOVF: result_q <= operand_q;
            OP_ADDWF: result_q <= DATA_W'(operand_q + w_o);
            OP_BCF: result_q <= operand_q & ~bit_mask;
            OP_BSF: result_q <= operand_q | bit_mask;
            OP_MOVLW: result_q <= exec_q[7:0];
            default: result_q <= '0;
          endcase
          dmem_o.wr <= exec_valid_q && dec.wr_f && !exec_internal;
          case (dec.op)
            OP_MOVWF: dmem_o.wdata <= w_o;
            OP_BCF: dmem_o.wdata <= operand_q & ~bit_mask;
            OP_BSF: dmem_o.wdata <= operand_q | bit_mask;
            OP_ADDWF: dmem_o.wdata <= DATA_W'(operand_q + w_o);
            default: dmem_o.wdata <= operand_q;
          endcase
        end
        default:
        begin
          dmem_o.wr <= 1'b0;
        end
      endcase
    end
  end

  // Working register
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      w_o <= W_RESET;
    end
    else if (phase_q == PH_FOUR && exec_valid_q && dec.wr_w)
    begin
      w_o <= result_q;
    end
  end

  // Mirrored status and latch registers, one copy each
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      status_o <= STATUS_RESET;
      pclath_q <= PCLATH_RESET;
    end
    else if (phase_q == PH_FOUR && exec_valid_q)
    begin
      if (dec.wr_f && exec_q[6:0] == STATUS_OFFS)
      begin
        status_o <= result_q;
      end
      else if (dec.op == OP_MOVF || dec.op == OP_ADDWF)
      begin
        status_o[ZERO_BIT] <= (result_q == '0);
      end
      if (dec.wr_f && exec_q[6:0] == PCLATH_OFFS)
      begin
        pclath_q <= result_q;
      end
    end
  end

endmodule : cfs_core_fetch_execute_sequencer

`default_nettype wire

// ===== test/cfs_props.sv
// Checker for the fetch and execute sequencer
`timescale 1ns/1ps
`default_nettype none
module cfs_props
  import cfs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [cfs_pkg::PC_W-1:0] prog_addr_o,
  input wire logic [3:0] phase_o,
  input wire cfs_pkg::cfs_dmem_req_type dmem_o,
  input wire logic irq_ack_o,
  input wire logic [cfs_pkg::DATA_W-1:0] status_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_rest;
    phase_o[1] ##1 phase_o[2] ##1 phase_o[3] ##1 phase_o[0];
  endsequence
  sequence s_vec;
    phase_o[0] ##1 prog_addr_o == INT_VECTOR;
  endsequence
  property p_rot;
    phase_o[0] |=> s_rest;
  endproperty
  a_rot: assert property (p_rot) else $error("phase order");
  property p_hot;
    $onehot(phase_o);
  endproperty
  a_hot: assert property (p_hot) else $error("phase code");
  property p_pc;
    phase_o[1] |=> $stable(prog_addr_o)[*3];
  endproperty
  a_pc: assert property (p_pc) else $error("pc moved");
  property p_rd;
    dmem_o.rd |-> phase_o[1] ##1 !dmem_o.rd;
  endproperty
  a_rd: assert property (p_rd) else $error("read phase");
  property p_wr;
    dmem_o.wr |-> phase_o[3];
  endproperty
  a_wr: assert property (p_wr) else $error("write phase");
  property p_hold;
    dmem_o.rd |=> $stable(dmem_o.addr)[*3];
  endproperty
  a_hold: assert property (p_hold) else $error("addr moved");
  property p_bank;
    dmem_o.rd |-> dmem_o.addr[8:7] == status_o[6:5];
  endproperty
  a_bank: assert property (p_bank) else $error("bank");
  property p_sfr;
    (dmem_o.rd || dmem_o.wr) |-> dmem_o.sfr == (dmem_o.addr[6:0] < SFR_TOP);
  endproperty
  a_sfr: assert property (p_sfr) else $error("sfr flag");
  property p_mir;
    (dmem_o.rd || dmem_o.wr) |-> dmem_o.addr[6:0] != STATUS_OFFS &&
      dmem_o.addr[6:0] != PCLATH_OFFS;
  endproperty
  a_mir: assert property (p_mir) else $error("mirror");
  property p_ack;
    irq_ack_o |-> s_vec;
  endproperty
  a_ack: assert property (p_ack) else $error("vector");
endmodule : cfs_props
bind cfs_core_fetch_execute_sequencer cfs_props i_cfs_props (.clk_i,
  .reset_i, .prog_addr_o, .phase_o, .dmem_o, .irq_ack_o, .status_o);
`default_nettype wire

// ===== test/cfs_mem_model.sv
// Program and banked data memory model
`timescale 1ns/1ps
`default_nettype none
module cfs_mem_model
  import cfs_pkg::*;
(
  input wire logic clk_i,
  input wire logic [cfs_pkg::PC_W-1:0] prog_addr_i,
  input wire cfs_pkg::cfs_dmem_req_type dmem_i,
  output logic [cfs_pkg::INSN_W-1:0] prog_word_o,
  output logic [cfs_pkg::DATA_W-1:0] dmem_rdata_o
);
  logic [INSN_W-1:0] rom [2**PC_W];
  logic [DATA_W-1:0] ram [2**DADDR_W];
  logic [DATA_W-1:0] last_q;
  assign prog_word_o = rom[prog_addr_i & PROG_MASK];
  assign dmem_rdata_o = dmem_i.rd ? ram[dmem_i.addr] : ~last_q;
  always_ff @(posedge clk_i)
  begin
    if (dmem_i.rd)
      last_q <= ram[dmem_i.addr];
    if (dmem_i.wr)
      ram[dmem_i.addr] <= dmem_i.wdata;
  end
endmodule : cfs_mem_model
`default_nettype wire

// ===== test/tb.sv
// Testbench for the fetch and execute sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cfs_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic irq_i = 1'b0;
  logic [INSN_W-1:0] word;
  logic [DATA_W-1:0] rdata, w, status;
  logic [PC_W-1:0] paddr;
  logic [3:0] phase;
  logic ack;
  cfs_dmem_req_type dmem;
  int n_mismatch = 0;
  int check_count = 0;
  always #12.5 clk_i = ~clk_i;
  cfs_core_fetch_execute_sequencer i_cfs_core_fetch_execute_sequencer (
    .clk_i, .reset_i, .prog_word_i(word), .dmem_rdata_i(rdata), .irq_i,
    .prog_addr_o(paddr), .phase_o(phase), .dmem_o(dmem), .irq_ack_o(ack),
    .w_o(w), .status_o(status));
  cfs_mem_model i_cfs_mem_model (.clk_i, .prog_addr_i(paddr),
    .dmem_i(dmem), .prog_word_o(word), .dmem_rdata_o(rdata));
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_until(input bit on_ack);
    int i;
    i = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      i++;
    end
    while ((on_ack ? ack : phase[1]) !== 1'b1 && i < 64);
    if (i >= 64)
    begin
      n_mismatch++;
      end_of_test();
    end
  endtask : wait_until
  task automatic t_reset;
    @(posedge clk_i) reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    check(16'(phase), 16'h0001);
    check(16'(paddr), 16'(RESET_VECTOR));
    check(16'(status), 16'(STATUS_RESET));
    @(posedge clk_i) reset_i <= 1'b0;
  endtask : t_reset
  task automatic t_program;
    int seq [12] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 12, 13};
    foreach (seq[k])
    begin
      wait_until(1'b0);
      check(16'(paddr), 16'(seq[k]));
    end
    check(16'(i_cfs_mem_model.ram[9'h020]), 16'h0055);
    check(16'(i_cfs_mem_model.ram[9'h0a0]), 16'h0055);
    check(16'(i_cfs_mem_model.ram[9'h0a1]), 16'h0055);
    check(16'(i_cfs_mem_model.ram[9'h022]), 16'h0055);
    check(16'(status), 16'(STATUS_RESET));
    check(16'(w), 16'h00aa);
  endtask : t_program
  task automatic t_irq;
    t_reset();
    @(posedge clk_i) irq_i <= 1'b1;
    wait_until(1'b1);
    check(16'(phase), 16'h0001);
    @(posedge clk_i) irq_i <= 1'b0;
    #1;
    check(16'(paddr), 16'(INT_VECTOR));
  endtask : t_irq
  initial
  begin
    for (int a = 0; a < 2**PC_W; a++)
      i_cfs_mem_model.rom[a] = NOP_WORD;
    i_cfs_mem_model.rom[0] = 14'h3055;
    i_cfs_mem_model.rom[1] = 14'h00a0;
    i_cfs_mem_model.rom[2] = 14'h1683;
    i_cfs_mem_model.rom[3] = 14'h00a0;
    i_cfs_mem_model.rom[4] = 14'h2808;
    i_cfs_mem_model.rom[5] = 14'h30ff;
    i_cfs_mem_model.rom[8] = 14'h00a1;
    i_cfs_mem_model.rom[9] = 14'h1283;
    i_cfs_mem_model.rom[10] = 14'h00a2;
    i_cfs_mem_model.rom[11] = 14'h0722;
    t_reset();
    t_program();
    t_irq();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
